// ==== rtl/pfs_fault_summary.sv ====
// Fault summary byte and word, alert and input current warning limit.
`timescale 1ns/10ps
`default_nettype none
module pfs_fault_summary (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Command port from the bus transport
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [pfs_pkg::CMD_W-1:0] cmd_code,
    input wire logic [pfs_pkg::WORD_W-1:0] cmd_wdata,
    output logic cmd_ack,
    output logic cmd_err,
    output logic [pfs_pkg::WORD_W-1:0] cmd_rdata,
    // Fault causes from the detection logic
    input wire logic [pfs_pkg::NUM_EVT-1:0] fault_evt,
    input wire logic output_off,
    input wire logic regulator_ready_pin,
    input wire logic [15:0] iin_reading,
    // Alert and current limit
    output logic fault_alert_line,
    output logic [pfs_pkg::LIM_EXP_W-1:0] input_warn_limit_exp,
    output logic [pfs_pkg::LIM_MANT_W-1:0] input_warn_limit_mant
);
    import pfs_pkg::*;

    // The bank sits between the bus transport and the fault detectors.
    // Detail causes arrive as single-cycle or level strobes and are
    // latched in a bank of sticky flags; the summary byte and word are
    // then plain functions of those flags and of two raw inputs. Only
    // the answer to a read is registered, so a summary changes on the
    // edge after its cause and never glitches on the bus side.

    // All state of the block in one record.
    typedef struct packed {
        logic rdy_meta;
        logic rdy_sync;
        logic [LIM_EXP_W-1:0] lim_exp;
        logic [LIM_MANT_W-1:0] lim_mant;
        logic [WORD_W-1:0] rdata;
        logic ack;
        logic err;
        logic alert;
    } pfs_state_type;

    // Decoded command kinds.
    // Code 3'b111 is never produced; the default branch of the
    // next-state case answers nothing if it ever appeared.
    typedef enum logic [2:0] {
        PFS_OP_NONE = 3'b000,
        PFS_OP_CLEAR = 3'b001,
        PFS_OP_LIM_WR = 3'b010,
        PFS_OP_LIM_RD = 3'b011,
        PFS_OP_BYTE_RD = 3'b100,
        PFS_OP_WORD_RD = 3'b101,
        PFS_OP_BAD = 3'b110
    } pfs_op_type;

    pfs_state_type state_reg;
    pfs_state_type state_next;
    pfs_op_type op;
    logic iin_over;
    logic [NUM_FLAG-1:0] flags;
    logic [NUM_FLAG-1:0] alert_mask;
    logic [7:0] sum_byte;
    logic [WORD_W-1:0] sum_word;
    logic [WORD_W-1:0] lim_word;
    logic cat_vout;
    logic cat_iout;
    logic cat_input;
    logic cat_other;
    logic cat_temp;

    // Set, clear and flag state travel together to the flag bank.
    pfs_flag_if #(.N(NUM_FLAG)) fl ();

    // Latched detail causes; one bit per distinct cause.
    // Each cause owns a flag of its own so that a category bit and the
    // other bit can share it without double latching. The bank gives a
    // live cause priority over a clear, so a persisting fault is never
    // lost between the clear and the next detection.
    pfs_flag_bank #(
        .N(NUM_FLAG)
    ) u_flags (
        .clk(clk),
        .rstn(rstn),
        .fl(fl)
    );

    // Input current warning detector on the live limit.
    // The comparison is registered, which adds one cycle between a
    // reading crossing the limit and its flag. A new limit takes effect
    // on the cycle after the write is answered.
    pfs_limit_cmp u_iin_cmp (
        .clk(clk),
        .rstn(rstn),
        .limit_exp(state_reg.lim_exp),
        .limit_mant(state_reg.lim_mant),
        .reading(iin_reading),
        .over_limit(iin_over)
    );

    // current warning cause
    // The warning joins the external causes as the top flag bit.
    // Its position matches the index the package gives it.
    assign fl.set = {iin_over, fault_evt};

    // clear-faults command
    // The clear acts in the request cycle; a live cause sets again.
    // Only a write of the clear code clears; a read of it is refused.
    assign fl.clear = (op == PFS_OP_CLEAR);

    assign flags = fl.flags;

    // Command decode. Writes to the status codes are refused
    // because both summaries are read only.
    // A refused request is still answered, with the error bit up and
    // zero data, so the transport never waits on a missing answer.
    // Refusals touch neither the flags nor the limit.
    always_comb begin
        op = PFS_OP_NONE;
        if (cmd_valid) begin
            case (cmd_code)
                CMD_CLEAR_FAULTS: begin
                    op = cmd_write ? PFS_OP_CLEAR : PFS_OP_BAD;
                end
                CMD_IIN_OC_WARN: begin
                    op = cmd_write ? PFS_OP_LIM_WR : PFS_OP_LIM_RD;
                end
                // Byte and word reads each take the live flags in their own request cycle.
                CMD_SUM_BYTE: begin
                    op = cmd_write ? PFS_OP_BAD : PFS_OP_BYTE_RD;
                end
                CMD_SUM_WORD: begin
                    op = cmd_write ? PFS_OP_BAD : PFS_OP_WORD_RD;
                end
                default: begin
                    op = PFS_OP_BAD;
                end
            endcase
        end
    end

    // category from details
    // Categories are plain ORs, so a category stays up exactly as
    // long as one of its detail flags does.
    always_comb begin
        cat_vout = flags[SRC_VOUT_OV] |
            flags[SRC_VOUT_UV] |
            flags[SRC_VOUT_MAX];
        cat_iout = flags[SRC_IOUT_OC] |
            flags[SRC_IOUT_WARN];
        // The input current warning counts as an input cause, like the
        // input overcurrent fault and the supply lockout.
        cat_input = flags[SRC_VIN_UV] |
            flags[SRC_IIN_OCF] |
            flags[SRC_IIN_WARN];
        cat_temp = flags[SRC_OT_FAULT] |
            flags[SRC_OT_WARN];
        // other summary bit
        // Causes with no bit of their own in 6:1 or 12 land here.
        cat_other = flags[SRC_VOUT_UV] |
            flags[SRC_VOUT_MAX] |
            flags[SRC_IOUT_WARN] |
            flags[SRC_IIN_OCF] |
            flags[SRC_IIN_WARN];
        // A maker fault has a word bit of its own and so stays out of
        // the other bit.
    end

    // Summary byte, which is also the low byte of the word.
    // Building it once and reusing it in the word keeps the two
    // commands from ever disagreeing about a flag.
    always_comb begin
        sum_byte = 8'h00;
        sum_byte[SB_BUSY] = 1'b0;
        // raw output off
        // Taken live, never latched, so it drops as power returns.
        sum_byte[SB_OFF] = output_off;
        sum_byte[SB_VOUT_OV] = flags[SRC_VOUT_OV];
        sum_byte[SB_IOUT_OC] = flags[SRC_IOUT_OC];
        sum_byte[SB_VIN_UV] = flags[SRC_VIN_UV];
        sum_byte[SB_TEMP] = cat_temp;
        sum_byte[SB_CML] = flags[SRC_CML];
        sum_byte[SB_OTHER] = cat_other;
    end

    // Summary word built around the same byte.
    // The not-ready bit is the only input here that crosses a clock
    // boundary; it lags the pin by two edges.
    always_comb begin
        sum_word = 16'h0000;
        sum_word[7:0] = sum_byte;
        sum_word[SW_VOUT] = cat_vout;
        sum_word[SW_IOUT] = cat_iout;
        sum_word[SW_INPUT] = cat_input;
        sum_word[SW_MFR] = flags[SRC_MFR];
        // inverted ready pin
        // Read from the second synchroniser stage only.
        sum_word[SW_NOT_READY] = ~state_reg.rdy_sync;
        sum_word[10:8] = 3'h0;
    end

    // limit word layout
    // Fields sit in the word exactly as software writes them.
    // Reading the limit back returns the same bits that were written,
    // including a negative exponent or mantissa.
    always_comb begin
        lim_word = 16'h0000;
        lim_word[LIM_EXP_LSB +: LIM_EXP_W] = state_reg.lim_exp;
        lim_word[LIM_MANT_LSB +: LIM_MANT_W] = state_reg.lim_mant;
    end

    // alert without input UV
    // Input undervoltage is the one latched cause left off the
    // alert, since the supply sagging at power-down is expected.
    // The flag itself is still latched and reported in both summaries;
    // only the alert ignores it.
    always_comb begin
        alert_mask = '1;
        alert_mask[SRC_VIN_UV] = 1'b0;
    end

    // Next-state logic for the whole block.
    // Read data is loaded only when a request is answered and holds in
    // between, so a slow transport may pick it up after the ack pulse.
    // Writes and refusals load zero rather than leaving stale data.
    always_comb begin
        state_next = state_reg;
        // Ready pin comes from outside; two stages before use.
        state_next.rdy_meta = regulator_ready_pin;
        state_next.rdy_sync = state_reg.rdy_meta;
        // The alert follows the latched flags one cycle later.
        state_next.alert = |(flags & alert_mask);
        state_next.ack = 1'b0;
        state_next.err = 1'b0;
        case (op)
            PFS_OP_NONE: begin
                state_next.ack = 1'b0;
            end
            PFS_OP_CLEAR: begin
                state_next.ack = 1'b1;
                state_next.rdata = 16'h0000;
            end
            PFS_OP_LIM_WR: begin
                state_next.ack = 1'b1;
                state_next.rdata = 16'h0000;
                state_next.lim_exp =
                    cmd_wdata[LIM_EXP_LSB +: LIM_EXP_W];
                state_next.lim_mant =
                    cmd_wdata[LIM_MANT_LSB +: LIM_MANT_W];
            end
            PFS_OP_LIM_RD: begin
                state_next.ack = 1'b1;
                state_next.rdata = lim_word;
            end
            PFS_OP_BYTE_RD: begin
                state_next.ack = 1'b1;
                state_next.rdata = {8'h00, sum_byte};
            end
            PFS_OP_WORD_RD: begin
                state_next.ack = 1'b1;
                state_next.rdata = sum_word;
            end
            PFS_OP_BAD: begin
                // Refused requests answer with zero data.
                state_next.ack = 1'b1;
                state_next.err = 1'b1;
                state_next.rdata = 16'h0000;
            end
            default: begin
                state_next.ack = 1'b0;
            end
        endcase
    end

    // limit reset value
    // The ready stages reset high so that the not-ready bit reads
    // zero until a real pin level has passed through.
    // Every field is reset by name so that the ready stages can come up
    // high while everything else comes up at zero or its reset value.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg.rdy_meta <= 1'b1;
            state_reg.rdy_sync <= 1'b1;
            state_reg.lim_exp <= LIM_RESET[LIM_EXP_LSB +: LIM_EXP_W];
            state_reg.lim_mant <=
                LIM_RESET[LIM_MANT_LSB +: LIM_MANT_W];
            state_reg.rdata <= 16'h0000;
            state_reg.ack <= 1'b0;
            state_reg.err <= 1'b0;
            state_reg.alert <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state record.
    // Nothing here is combinational, so every output changes only on a
    // rising clock edge or at reset.
    assign cmd_ack = state_reg.ack;
    assign cmd_err = state_reg.err;
    assign cmd_rdata = state_reg.rdata;
    assign fault_alert_line = state_reg.alert;
    assign input_warn_limit_exp = state_reg.lim_exp;
    assign input_warn_limit_mant = state_reg.lim_mant;
endmodule : pfs_fault_summary
`default_nettype wire

// ==== rtl/pfs_pkg.sv ====
// Shared constants of the fault summary register bank.
package pfs_pkg;
    // Command codes seen on the command port.
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_IIN_OC_WARN = 8'h5d;
    localparam logic [7:0] CMD_SUM_BYTE = 8'h78;
    localparam logic [7:0] CMD_SUM_WORD = 8'h79;
    localparam int CMD_W = 8;
    localparam int WORD_W = 16;
    // Warning limit field layout and reset value.
    localparam int LIM_EXP_LSB = 11;
    localparam int LIM_EXP_W = 5;
    localparam int LIM_MANT_LSB = 0;
    localparam int LIM_MANT_W = 11;
    localparam logic [15:0] LIM_RESET = 16'h0019;
    // Positions of the latched detail causes in the flag vector.
    localparam int SRC_VOUT_OV = 0;
    localparam int SRC_VOUT_UV = 1;
    localparam int SRC_VOUT_MAX = 2;
    localparam int SRC_IOUT_OC = 3;
    localparam int SRC_IOUT_WARN = 4;
    localparam int SRC_VIN_UV = 5;
    localparam int SRC_IIN_OCF = 6;
    localparam int SRC_OT_FAULT = 7;
    localparam int SRC_OT_WARN = 8;
    localparam int SRC_CML = 9;
    localparam int SRC_MFR = 10;
    localparam int SRC_IIN_WARN = 11;
    localparam int NUM_EVT = 11;
    localparam int NUM_FLAG = 12;
    // Summary byte and word bit positions.
    localparam int SB_BUSY = 7;
    localparam int SB_OFF = 6;
    localparam int SB_VOUT_OV = 5;
    localparam int SB_IOUT_OC = 4;
    localparam int SB_VIN_UV = 3;
    localparam int SB_TEMP = 2;
    localparam int SB_CML = 1;
    localparam int SB_OTHER = 0;
    localparam int SW_VOUT = 15;
    localparam int SW_IOUT = 14;
    localparam int SW_INPUT = 13;
    localparam int SW_MFR = 12;
    localparam int SW_NOT_READY = 11;
endpackage : pfs_pkg

// ==== rtl/pfs_flag_if.sv ====
// Carrier between the summary logic and its sticky flag bank.
`timescale 1ns/10ps
`default_nettype none
interface pfs_flag_if #(
    parameter int N = 12
);
    logic [N-1:0] set;
    logic clear;
    logic [N-1:0] flags;
    modport bank (input set, input clear, output flags);
    modport user (output set, output clear, input flags);
endinterface : pfs_flag_if
`default_nettype wire

// ==== rtl/pfs_flag_bank.sv ====
// Sticky fault flags with a common clear in which a set always wins.
`timescale 1ns/10ps
`default_nettype none
module pfs_flag_bank #(
    parameter int N = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Set, clear and flag state
    pfs_flag_if.bank fl
);
    import pfs_pkg::*;

    typedef struct packed {
        logic [N-1:0] flags;
    } pfs_bank_state_type;

    pfs_bank_state_type state_reg;
    pfs_bank_state_type state_next;
    logic [N-1:0] flag_next;

    // hold until clear
    // A cause present in the clearing cycle keeps its flag set.
    for (genvar i = 0; i < N; i++) begin : g_flag
        assign flag_next[i] = fl.set[i] |
            (state_reg.flags[i] & ~fl.clear);
    end

    // Next state is only the per-bit result.
    always_comb begin
        state_next = state_reg;
        state_next.flags = flag_next;
    end

    // Flags come up cleared.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign fl.flags = state_reg.flags;
endmodule : pfs_flag_bank
`default_nettype wire

// ==== rtl/pfs_limit_cmp.sv ====
// Compares an input current reading against a linear-format limit.
`timescale 1ns/10ps
`default_nettype none
module pfs_limit_cmp (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Limit fields and reading in whole amperes
    input wire logic [4:0] limit_exp,
    input wire logic [10:0] limit_mant,
    input wire logic [15:0] reading,
    // Registered result
    output logic over_limit
);
    import pfs_pkg::*;

    typedef struct packed {
        logic over;
    } pfs_cmp_state_type;

    pfs_cmp_state_type state_reg;
    pfs_cmp_state_type state_next;
    logic [47:0] lhs;
    logic [47:0] rhs;
    logic [4:0] neg_exp;

    // Scale the side that avoids losing fraction bits of the limit.
    always_comb begin
        neg_exp = 5'(~limit_exp + 5'h01);
        if (limit_exp[4]) begin
            lhs = {32'h0000_0000, reading} << neg_exp;
            rhs = {37'h0, limit_mant};
        end else begin
            lhs = {32'h0000_0000, reading};
            rhs = {37'h0, limit_mant} << limit_exp;
        end
        state_next = state_reg;
        // A negative limit is below any reading, so it always trips.
        state_next.over = limit_mant[10] | (lhs > rhs);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign over_limit = state_reg.over;
endmodule : pfs_limit_cmp
`default_nettype wire

// ==== bench/pfs_fault_summary_asserts.sv ====
// Concurrent checks on the fault summary bank, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module pfs_fault_summary_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [pfs_pkg::CMD_W-1:0] cmd_code,
    input wire logic [pfs_pkg::WORD_W-1:0] cmd_wdata,
    input wire logic cmd_ack,
    input wire logic cmd_err,
    input wire logic [pfs_pkg::WORD_W-1:0] cmd_rdata,
    // Causes and results
    input wire logic [pfs_pkg::NUM_EVT-1:0] fault_evt,
    input wire logic output_off,
    input wire logic regulator_ready_pin,
    input wire logic fault_alert_line,
    input wire logic [pfs_pkg::LIM_EXP_W-1:0] input_warn_limit_exp,
    input wire logic [pfs_pkg::LIM_MANT_W-1:0] input_warn_limit_mant
);
    import pfs_pkg::*;
    logic rd_b;
    logic rd_w;
    logic wr_ro;

    // Decoded requests, kept apart so the properties stay short.
    assign rd_b = cmd_valid && !cmd_write && cmd_code == CMD_SUM_BYTE;
    assign rd_w = cmd_valid && !cmd_write && cmd_code == CMD_SUM_WORD;
    assign wr_ro = cmd_valid && cmd_write &&
        (cmd_code == CMD_SUM_BYTE || cmd_code == CMD_SUM_WORD);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_ack; cmd_valid |=> cmd_ack; endproperty
    a_ack: assert property (p_ack) else $error("no answer");
    property p_byte; rd_b |=> !cmd_err && cmd_rdata[15:7] == 9'h000;
    endproperty
    a_byte: assert property (p_byte) else $error("byte upper");
    property p_resv; rd_w |=> cmd_rdata[10:7] == 4'h0; endproperty
    a_resv: assert property (p_resv) else $error("reserved set");
    property p_off; rd_b || rd_w |=> cmd_rdata[6] == $past(output_off);
    endproperty
    a_off: assert property (p_off) else $error("off bit");
    property p_ov; fault_evt[SRC_VOUT_OV] ##1 rd_w |=>
        cmd_rdata[5] && cmd_rdata[15]; endproperty
    a_ov: assert property (p_ov) else $error("ov flag");
    property p_alert; fault_evt[SRC_IOUT_OC] |-> ##2 fault_alert_line;
    endproperty
    a_alert: assert property (p_alert) else $error("alert late");
    property p_rdy; rd_w && $stable(regulator_ready_pin) && $past(rstn, 2)
        && $past(regulator_ready_pin) == $past(regulator_ready_pin, 2)
        |=> cmd_rdata[11] == !$past(regulator_ready_pin); endproperty
    a_rdy: assert property (p_rdy) else $error("ready bit");
    property p_lim; cmd_valid && cmd_write && cmd_code == CMD_IIN_OC_WARN
        |=> {input_warn_limit_exp, input_warn_limit_mant} ==
        $past(cmd_wdata); endproperty
    a_lim: assert property (p_lim) else $error("limit write");
    property p_ro; wr_ro |=> cmd_err && cmd_rdata == 16'h0000; endproperty
    a_ro: assert property (p_ro) else $error("read-only hit");

    // Main scenarios reached.
    c_word: cover property (rd_w ##1 cmd_rdata[15]);
    c_alert: cover property ($rose(fault_alert_line));
    c_clear: cover property (cmd_valid && cmd_code == CMD_CLEAR_FAULTS);
endmodule : pfs_fault_summary_asserts

bind pfs_fault_summary pfs_fault_summary_asserts i_asserts (
    .clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_ack(cmd_ack),
    .cmd_err(cmd_err), .cmd_rdata(cmd_rdata), .fault_evt(fault_evt),
    .output_off(output_off), .regulator_ready_pin(regulator_ready_pin),
    .fault_alert_line(fault_alert_line),
    .input_warn_limit_exp(input_warn_limit_exp),
    .input_warn_limit_mant(input_warn_limit_mant));
`default_nettype wire

// ==== bench/pfs_host_model.sv ====
// Host model that issues status and limit commands to the bank.
`timescale 1ns/10ps
`default_nettype none
module pfs_host_model (
    // Clock
    input wire logic clk,
    // Requests toward the bank
    output logic cmd_valid,
    output logic cmd_write,
    output logic [pfs_pkg::CMD_W-1:0] cmd_code,
    output logic [pfs_pkg::WORD_W-1:0] cmd_wdata,
    // Answers from the bank
    input wire logic cmd_ack,
    input wire logic cmd_err,
    input wire logic [pfs_pkg::WORD_W-1:0] cmd_rdata
);
    import pfs_pkg::*;

    // Idle port at time zero.
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end

    // One-cycle request, then a bounded wait for the answer pulse.
    // Released qualifiers flip so a stale value is never mistaken.
    task automatic xfer(input logic wr, input logic [7:0] code,
        input logic [15:0] wd, output logic [15:0] rd, output logic er);
        int n;
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_code = code;
        cmd_wdata = wd;
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_write = ~wr;
        cmd_code = ~code;
        cmd_wdata = ~wd;
        n = 0;
        while (cmd_ack !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        rd = (n < 4) ? cmd_rdata : 16'hxxxx;
        er = (n < 4) ? cmd_err : 1'bx;
    endtask : xfer
endmodule : pfs_host_model
`default_nettype wire

// ==== bench/pfs_fault_summary_tb.sv ====
// Self-checking bench for the fault summary register bank.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
    failures++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module pfs_fault_summary_tb;
    import pfs_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cmd_valid, cmd_write, cmd_ack, cmd_err, alert, er;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata, rd, w;
    logic [15:0] iin_reading = 16'h0000;
    logic [10:0] fault_evt = 11'h000;
    logic output_off = 1'b0;
    logic pin = 1'b1;
    logic [4:0] lim_exp;
    logic [10:0] lim_mant;
    logic [11:0] lat = 12'h000;
    int failures = 0;
    int num_checks = 0;
    int seed_ret;

    // 200 MHz clock.
    always #2.5 clk = ~clk;

    pfs_fault_summary i_dut (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .cmd_ack(cmd_ack), .cmd_err(cmd_err), .cmd_rdata(cmd_rdata),
        .fault_evt(fault_evt), .output_off(output_off),
        .regulator_ready_pin(pin), .iin_reading(iin_reading),
        .fault_alert_line(alert), .input_warn_limit_exp(lim_exp),
        .input_warn_limit_mant(lim_mant));
    pfs_host_model i_host (.clk(clk), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .cmd_ack(cmd_ack), .cmd_err(cmd_err), .cmd_rdata(cmd_rdata));

    // Expected word from the latched causes; index order follows fault_evt,
    // with 11 standing for the input current warning.
    function automatic logic [15:0] exp_word(logic [11:0] l, logic off,
        logic p);
        logic [15:0] e;
        e = 16'h0000;
        e[15] = l[0] | l[1] | l[2];
        e[14] = l[3] | l[4];
        e[13] = l[5] | l[6] | l[11];
        e[12] = l[10];
        e[11] = ~p;
        e[6] = off;
        e[5] = l[0];
        e[4] = l[3];
        e[3] = l[5];
        e[2] = l[7] | l[8];
        e[1] = l[9];
        e[0] = l[1] | l[2] | l[4] | l[6] | l[11];
        return e;
    endfunction : exp_word

    // Reads both summaries and the alert against the shadow state.
    task automatic check_all();
        logic [15:0] ew;
        ew = exp_word(lat, output_off, pin);
        i_host.xfer(1'b0, CMD_SUM_WORD, 16'h0000, rd, er);
        `CHK("word", ew, rd)
        i_host.xfer(1'b0, CMD_SUM_BYTE, 16'h0000, rd, er);
        `CHK("byte", {8'h00, ew[7:0]}, rd)
        `CHK("alert", |(lat & 12'hfdf), alert)
    endtask : check_all

    // A single-cycle cause pulse.
    task automatic pulse(input int i);
        @(negedge clk);
        fault_evt[i] = 1'b1;
        @(negedge clk);
        fault_evt[i] = 1'b0;
        lat[i] = 1'b1;
    endtask : pulse

    task automatic clear_all();
        i_host.xfer(1'b1, CMD_CLEAR_FAULTS, 16'h0000, rd, er);
        lat = 12'h000;
    endtask : clear_all

    task automatic close_out();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    // Watchdog sized well beyond the several hundred cycles the run needs.
    initial begin
        #(20000 * 5);
        failures++;
        close_out();
    end

    // Main sequence.
    initial begin
        seed_ret = $urandom(54892);
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        i_host.xfer(1'b0, CMD_IIN_OC_WARN, 16'h0000, rd, er);
        `CHK("limit rst", 16'h0019, rd)
        check_all();
        i_host.xfer(1'b1, CMD_SUM_WORD, 16'hffff, rd, er);
        `CHK("ro err", 1'b1, er)
        pulse(5);
        // Refused requests answer zero and leave the flags alone.
        i_host.xfer(1'b0, CMD_CLEAR_FAULTS, 16'h0000, rd, er);
        `CHK("clr rd", 17'h10000, {er, rd})
        i_host.xfer(1'b1, CMD_SUM_BYTE, 16'hffff, rd, er);
        `CHK("byte wr", 17'h10000, {er, rd})
        check_all();
        clear_all();
        // Random causes with random raw inputs, cleared now and then.
        repeat (60) begin
            output_off = 1'($urandom_range(0, 1));
            pin = 1'($urandom_range(0, 1));
            iin_reading = 16'($urandom_range(0, 25));
            pulse($urandom_range(0, 10));
            repeat (3) @(negedge clk);
            check_all();
            if ($urandom_range(0, 3) == 0) clear_all();
        end
        // A cause held through the clear must survive it.
        fault_evt[3] = 1'b1;
        clear_all();
        fault_evt[3] = 1'b0;
        lat[3] = 1'b1;
        check_all();
        clear_all();
        check_all();
        // A cause one cycle ahead of a word read is already in it.
        fault_evt[0] = 1'b1;
        i_host.xfer(1'b0, CMD_SUM_WORD, 16'h0000, rd, er);
        fault_evt[0] = 1'b0;
        lat[0] = 1'b1;
        `CHK("ov word", exp_word(lat, output_off, pin), rd)
        // Random limit words; iin stays low but a negative limit may trip.
        iin_reading = 16'h0000;
        repeat (8) begin
            w = 16'($urandom);
            i_host.xfer(1'b1, CMD_IIN_OC_WARN, w, rd, er);
            `CHK("lim exp", w[15:11], lim_exp)
            `CHK("lim mant", w[10:0], lim_mant)
            i_host.xfer(1'b0, CMD_IIN_OC_WARN, 16'h0000, rd, er);
            `CHK("lim rd", w, rd)
        end
        // Reset in mid-run restores the limit and drops every flag.
        pulse(10);
        rstn = 1'b0;
        lat = 12'h000;
        repeat (3) @(negedge clk);
        `CHK("alert rst", 1'b0, alert)
        rstn = 1'b1;
        i_host.xfer(1'b0, CMD_IIN_OC_WARN, 16'h0000, rd, er);
        `CHK("limit rst2", 16'h0019, rd)
        check_all();
        // Reading equal to the limit is not over it; one more ampere is.
        iin_reading = 16'd25;
        repeat (4) @(negedge clk);
        check_all();
        iin_reading = 16'd26;
        repeat (4) @(negedge clk);
        `CHK("iin warn", 1'b1, alert)
        lat[11] = 1'b1;
        iin_reading = 16'h0000;
        check_all();
        close_out();
    end
endmodule : pfs_fault_summary_tb
`default_nettype wire
